// ### rtl/fqwc_pkg.sv
package fqwc_pkg;
	// ----------------------------------------------------------------
	// clock and control tick
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000; // system clock rate
	localparam int CTRL_TICK_US = 1000; // control tick period in us
	localparam int CTRL_TICK_CYCLES = CLK_HZ / 1_000_000 * CTRL_TICK_US;
	localparam int DSEC_TICKS = 100; // control ticks in 0.1 s
	localparam int WK_SHIFT = 10; // weakening loop output scaling

	// ----------------------------------------------------------------
	// value ranges, all percentages in 0.01 % steps
	// ----------------------------------------------------------------
	localparam logic [31:0] PCT_FULL = 32'h0000_2710; // 100.00 %
	localparam logic [31:0] GAIN_MAX = 32'h0000_03E8; // gain 1000
	localparam logic [31:0] QUENCH_MAX = 32'h0000_1770; // 600.0 s
	localparam logic [13:0] FIELD_MIN_RATIO = 14'h03E8; // 10:1 of rated

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [9:0] INT_GAIN_RST = 10'h064; // 100
	localparam logic [13:0] IDLE_CUR_RST = 14'h09C4; // 25.00 %
	localparam logic [12:0] QUENCH_RST = 13'h0064; // 10.0 s
	localparam logic [13:0] FIELD_REF_RST = 14'h2710; // 100.00 %
	localparam logic [13:0] FLOOR_RST = 14'h03E8; // 10.00 %
	localparam logic [13:0] THRESH_RST = 14'h2328; // 90.00 %
	localparam logic [9:0] WK_GAIN_RST [5] = '{10'h032, 10'h010,
		10'h008, 10'h004, 10'h004}; // p, i, d, fb d, fb i
	localparam logic [15:0] TACH_FULLSCALE = 16'h2710; // tacho 100 %

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INT_GAIN = 8'h04;
	localparam logic [7:0] OFF_IDLE_CUR = 8'h08;
	localparam logic [7:0] OFF_QUENCH = 8'h0C;
	localparam logic [7:0] OFF_FIELD_REF = 8'h10;
	localparam logic [7:0] OFF_FLOOR = 8'h14;
	localparam logic [7:0] OFF_THRESH = 8'h18;
	localparam logic [7:0] OFF_WK_GAIN0 = 8'h1C; // five words
	localparam logic [7:0] OFF_WK_GAIN4 = 8'h2C;
	localparam logic [7:0] OFF_STATUS = 8'h30;
	localparam logic [7:0] OFF_DEMAND = 8'h34;
	localparam logic [7:0] OFF_INT_STAT = 8'h38;
	localparam logic [7:0] OFF_INT_CLR = 8'h3C;
	localparam logic [7:0] OFF_INT_EN = 8'h40;
	localparam logic [7:0] OFF_SPD_SCALE = 8'h44;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_IDLE_WARM = 0; // idle_warming_mode_on
	localparam int CTRL_WEAK_ON = 1; // weakening_loop_on
	localparam int CTRL_AVF_SEL = 2; // armature voltage feedback select
	localparam int CTRL_TRIP_CLR = 3; // write one to clear trip
	localparam int IRQ_STOP = 0; // non-running condition began
	localparam int IRQ_TRIP = 1; // disagreement trip
	localparam int IRQ_WEAK = 2; // weakening region entered

	// ----------------------------------------------------------------
	// sequencer states, gray along run -> hold -> idle
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		FQWC_RUN = 2'b00,
		FQWC_HOLD = 2'b01,
		FQWC_IDLE = 2'b11
	} fqwc_state_t;
endpackage : fqwc_pkg

// ### rtl/fqwc_sync.sv
module fqwc_sync
	import fqwc_pkg::*;
#(
	parameter int W = 3
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ----------------------------------------------------------------
	// two-stage synchroniser
	// ----------------------------------------------------------------
	logic [W-1:0] meta; // first stage, read only by q

	if (W < 1)
	begin : bad_width
		$error("fqwc_sync: width must be at least one");
	end

	// pins are asynchronous to clock
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : fqwc_sync

// ### rtl/fqwc_weak_ctl.sv
module fqwc_weak_ctl
	import fqwc_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic enable,
	input wire logic [13:0] thresh,
	input wire logic [13:0] vfb,
	input wire logic [9:0] kp,
	input wire logic [9:0] ki,
	input wire logic [9:0] kd,
	input wire logic [9:0] kfd,
	input wire logic [9:0] kfi,
	input wire logic [13:0] max_cut,
	output logic [13:0] cut
);
	// ----------------------------------------------------------------
	// weakening loop: five terms on spillover error and feedback
	// ----------------------------------------------------------------
	logic signed [16:0] err; // positive below threshold
	logic signed [16:0] prev_err; // error at last tick
	logic [13:0] prev_fb; // feedback at last tick
	logic signed [16:0] d_err; // error change
	logic signed [16:0] d_fb; // feedback change
	logic signed [31:0] integ; // combined integral store
	logic signed [31:0] next_integ;
	logic signed [31:0] sum; // loop output before scaling
	logic signed [31:0] cut_lim; // integral floor
	logic [31:0] neg_sum;

	// gain times signed quantity, 32-bit exact
	function automatic logic signed [31:0] gmul(input logic [9:0] g,
		input logic signed [16:0] x);
		gmul = $signed({22'h00_0000, g}) * $signed({{15{x[16]}}, x});
	endfunction : gmul

	// error, derivative and integral terms
	always_comb
	begin
		err = $signed({3'b000, thresh}) - $signed({3'b000, vfb}); // RQ8
		d_err = err - prev_err;
		d_fb = $signed({3'b000, vfb}) - $signed({3'b000, prev_fb});
		cut_lim = -$signed({18'h0_0000, max_cut} << WK_SHIFT);
		// error integral plus feedback integral; windup held in range
		next_integ = integ + gmul(ki, err) - gmul(kfi, d_fb); // RQ10
		if (next_integ > 0)
			next_integ = '0;
		else if (next_integ < cut_lim)
			next_integ = cut_lim;
		sum = next_integ + gmul(kp, err) + gmul(kd, d_err)
			- gmul(kfd, d_fb); // RQ10
		neg_sum = 32'(-sum) >> WK_SHIFT;
	end

	// loop state, advanced once per control tick
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			integ <= '0;
			prev_err <= '0;
			prev_fb <= '0;
			cut <= '0;
		end
		else if (!enable)
		begin
			integ <= '0; // no memory carried across disable
			prev_err <= '0;
			prev_fb <= vfb;
			cut <= '0;
		end
		else if (tick)
		begin
			integ <= next_integ;
			prev_err <= err;
			prev_fb <= vfb;
			// cut only lowers field; clamps voltage at spillover
			if (sum >= 0)
				cut <= '0; // RQ9
			else if (neg_sum > {18'h0_0000, max_cut})
				cut <= max_cut;
			else
				cut <= neg_sum[13:0]; // RQ9
		end
	end
endmodule : fqwc_weak_ctl

// ### rtl/fqwc_top.sv
// Contract
// RQ1: field loop integral gain 0..1000, default 100
// RQ2: idle: zero field, or idle current if on
// RQ3: running means run and (start or jog)
// RQ4: idle current 0..100.00 %, default 25.00 %
// RQ5: quench delay 0..600.0 s, field held meanwhile
// RQ6: field reference scales rated demand, default 100 %
// RQ7: reference below floor clamps demand to floor
// RQ8: weakening compares armature voltage with threshold
// RQ9: above threshold, lower field, hold voltage
// RQ10: weakening loop has five adjustable terms
// RQ11: weakening never cuts field beyond 10:1
// RQ12: feedback select plus weakening trips on entry
// RQ13: feedback change rescales speed full scale
// RQ14: run drop while stopping quenches immediately
// RQ15: run returning in delay cancels quench
//
// The address-and-strobe port and the register addresses were left to the implementer.
module fqwc_top
	import fqwc_pkg::*;
#(
	parameter int TICK_CYCLES = CTRL_TICK_CYCLES, // clocks per 1 ms
	parameter logic [15:0] RATED_ARM_V = 16'h01C2 // rated armature volts
)
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic run_pin,
	input wire logic start_pin,
	input wire logic jog_pin,
	input wire logic [13:0] armature_voltage,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [13:0] field_demand,
	output logic [9:0] field_int_gain,
	output logic contactor_on,
	output logic speed_feedback_disagreement_trip,
	output logic weakening_active,
	output logic [15:0] speed_fb_fullscale,
	output logic irq
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [2:0] pins_s; // synchronised run, start, jog
	logic run_s;
	logic running; // run condition
	logic [31:0] tick_cnt; // clock divider
	logic ms_tick; // one-cycle control tick
	logic [6:0] ds_cnt; // ticks within 0.1 s
	logic ds_tick; // one-cycle 0.1 s tick
	fqwc_state_t state;
	fqwc_state_t next_state;
	logic [12:0] quench_left; // remaining delay in 0.1 s
	logic idle_warming_mode_on;
	logic weakening_loop_on;
	logic avf_sel; // armature voltage feedback selected
	logic [13:0] idle_warming_current;
	logic [12:0] quench_hold_time;
	logic [13:0] field_ref;
	logic [13:0] field_current_floor;
	logic [13:0] weakening_threshold_voltage;
	logic [9:0] wk_gain [5]; // p, i, d, fb d, fb i
	logic [13:0] base_demand; // reference after floor clamp
	logic [13:0] weak_floor; // lowest weakened field
	logic [13:0] cut; // weakening reduction
	logic [13:0] next_demand;
	logic trip_set;
	logic [2:0] int_stat;
	logic [2:0] int_en;
	logic [2:0] int_ev;
	logic [31:0] next_rdata;
	logic wk_sel; // address falls in gain words
	logic [2:0] wk_idx;

	if (TICK_CYCLES < 2)
	begin : bad_tick
		$error("fqwc_top: TICK_CYCLES must be at least two");
	end

	// saturate a written value to its legal range
	function automatic logic [31:0] clamp_to(input logic [31:0] v,
		input logic [31:0] lim);
		clamp_to = (v > lim) ? lim : v;
	endfunction : clamp_to

	// ----------------------------------------------------------------
	// inputs and time base
	// ----------------------------------------------------------------
	fqwc_sync #(
		.W(3)
	) u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.d({run_pin, start_pin, jog_pin}),
		.q(pins_s)
	);

	assign run_s = pins_s[2];
	assign running = run_s & (pins_s[1] | pins_s[0]) // RQ3
		& ~speed_feedback_disagreement_trip;

	// 1 ms tick and 0.1 s tick from the one clock
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tick_cnt <= '0;
			ms_tick <= 1'b0;
			ds_cnt <= '0;
			ds_tick <= 1'b0;
		end
		else
		begin
			ms_tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
			ds_tick <= ms_tick && (ds_cnt == 7'(DSEC_TICKS - 1));
			if (tick_cnt == 32'(TICK_CYCLES - 1))
				tick_cnt <= '0;
			else
				tick_cnt <= tick_cnt + 32'h0000_0001;
			if (ms_tick)
				ds_cnt <= (ds_cnt == 7'(DSEC_TICKS - 1)) ? '0
					: ds_cnt + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	assign wk_sel = (reg_addr >= OFF_WK_GAIN0) && (reg_addr <= OFF_WK_GAIN4)
		&& (reg_addr[1:0] == 2'b00);
	assign wk_idx = 3'((reg_addr - OFF_WK_GAIN0) >> 2);

	// settings; out-of-range writes saturate rather than wrap
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			idle_warming_mode_on <= 1'b0;
			weakening_loop_on <= 1'b0;
			avf_sel <= 1'b0;
			field_int_gain <= INT_GAIN_RST;
			idle_warming_current <= IDLE_CUR_RST;
			quench_hold_time <= QUENCH_RST;
			field_ref <= FIELD_REF_RST;
			field_current_floor <= FLOOR_RST;
			weakening_threshold_voltage <= THRESH_RST;
			for (int i = 0; i < 5; i++)
				wk_gain[i] <= WK_GAIN_RST[i];
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				OFF_CTRL:
				begin
					idle_warming_mode_on <= reg_wdata[CTRL_IDLE_WARM];
					weakening_loop_on <= reg_wdata[CTRL_WEAK_ON];
					avf_sel <= reg_wdata[CTRL_AVF_SEL];
				end
				OFF_INT_GAIN:
					field_int_gain <= 10'(clamp_to(reg_wdata, GAIN_MAX)); // RQ1
				OFF_IDLE_CUR:
					idle_warming_current <=
						14'(clamp_to(reg_wdata, PCT_FULL)); // RQ4
				OFF_QUENCH:
					quench_hold_time <=
						13'(clamp_to(reg_wdata, QUENCH_MAX)); // RQ5
				OFF_FIELD_REF:
					field_ref <= 14'(clamp_to(reg_wdata, PCT_FULL)); // RQ6
				OFF_FLOOR:
					field_current_floor <= 14'(clamp_to(reg_wdata, PCT_FULL));
				OFF_THRESH:
					weakening_threshold_voltage <=
						14'(clamp_to(reg_wdata, PCT_FULL));
				default:
				begin
					// five loop terms share one indexed store
					if (wk_sel)
						wk_gain[wk_idx] <=
							10'(clamp_to(reg_wdata, GAIN_MAX)); // RQ10
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// run / hold / idle sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			FQWC_RUN:
			begin
				// run pin gone: no braking hold at all
				if (!running && !run_s)
					next_state = FQWC_IDLE; // RQ14
				else if (!running)
					next_state = (quench_hold_time == '0) ? FQWC_IDLE
						: FQWC_HOLD; // RQ5
			end
			FQWC_HOLD:
			begin
				if (running)
					next_state = FQWC_RUN; // RQ15
				else if (!run_s)
					next_state = FQWC_IDLE; // RQ14
				else if (ds_tick && quench_left <= 13'h0001)
					next_state = FQWC_IDLE; // RQ5
			end
			FQWC_IDLE:
			begin
				if (running)
					next_state = FQWC_RUN;
			end
			default:
				next_state = FQWC_IDLE;
		endcase
	end

	// state and delay timer; timer reloads on each stop
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= FQWC_IDLE;
			quench_left <= '0;
		end
		else
		begin
			state <= next_state;
			if (state != FQWC_HOLD)
				quench_left <= quench_hold_time; // RQ15
			else if (ds_tick && quench_left != '0)
				quench_left <= quench_left - 13'h0001; // RQ5
		end
	end

	// ----------------------------------------------------------------
	// field demand
	// ----------------------------------------------------------------
	fqwc_weak_ctl u_weak (
		.clock(clock),
		.arst_n(arst_n),
		.tick(ms_tick),
		.enable(weakening_loop_on && state == FQWC_RUN), // RQ8
		.thresh(weakening_threshold_voltage),
		.vfb(armature_voltage),
		.kp(wk_gain[0]),
		.ki(wk_gain[1]),
		.kd(wk_gain[2]),
		.kfd(wk_gain[3]),
		.kfi(wk_gain[4]),
		.max_cut(base_demand - weak_floor),
		.cut(cut)
	);

	// rated value is 100.00 %, so the reference is the scaled demand
	always_comb
	begin
		base_demand = (field_ref < field_current_floor)
			? field_current_floor : field_ref; // RQ6 RQ7
		// weakened field kept at or above a tenth of rated, or at base_demand when that is lower
		weak_floor = (base_demand < FIELD_MIN_RATIO) ? base_demand
			: FIELD_MIN_RATIO; // RQ11
		case (state)
			FQWC_RUN:
				// a stale cut after a lower reference must not wrap
				next_demand = (cut > base_demand - weak_floor) ? weak_floor
					: base_demand - cut; // RQ9 RQ11
			FQWC_HOLD:
				next_demand = base_demand; // RQ5
			FQWC_IDLE:
				next_demand = idle_warming_mode_on ? idle_warming_current
					: 14'h0000; // RQ2
			default:
				next_demand = 14'h0000;
		endcase
	end

	// demand, contactor and feedback scaling outputs
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			field_demand <= '0;
			contactor_on <= 1'b0;
			weakening_active <= 1'b0;
			speed_fb_fullscale <= TACH_FULLSCALE;
		end
		else
		begin
			field_demand <= next_demand;
			contactor_on <= (next_state == FQWC_RUN); // RQ14
			weakening_active <= (state == FQWC_RUN) && (cut != '0);
			// only a change of feedback mode rescales
			if (reg_wr && reg_addr == OFF_CTRL
				&& reg_wdata[CTRL_AVF_SEL] != avf_sel)
				speed_fb_fullscale <= reg_wdata[CTRL_AVF_SEL]
					? RATED_ARM_V : TACH_FULLSCALE; // RQ13
		end
	end

	// ----------------------------------------------------------------
	// disagreement trip
	// ----------------------------------------------------------------
	assign trip_set = avf_sel && weakening_loop_on
		&& (armature_voltage >= weakening_threshold_voltage); // RQ12

	// latched; set beats a clear in the same cycle
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			speed_feedback_disagreement_trip <= 1'b0;
		else if (trip_set)
			speed_feedback_disagreement_trip <= 1'b1; // RQ12
		else if (reg_wr && reg_addr == OFF_CTRL && reg_wdata[CTRL_TRIP_CLR])
			speed_feedback_disagreement_trip <= 1'b0;
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	assign int_ev[IRQ_STOP] = (state == FQWC_RUN) && (next_state != FQWC_RUN);
	assign int_ev[IRQ_TRIP] = trip_set && !speed_feedback_disagreement_trip;
	assign int_ev[IRQ_WEAK] = (state == FQWC_RUN) && (cut != '0)
		&& !weakening_active;

	// sticky status; a new event survives its own clear
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			int_stat <= '0;
			int_en <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == OFF_INT_CLR)
				int_stat <= (int_stat & ~reg_wdata[2:0]) | int_ev;
			else
				int_stat <= int_stat | int_ev;
			if (reg_wr && reg_addr == OFF_INT_EN)
				int_en <= reg_wdata[2:0];
			irq <= |(int_stat & int_en);
		end
	end

	// ----------------------------------------------------------------
	// register reads, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_comb
	begin
		next_rdata = '0;
		case (reg_addr)
			OFF_CTRL:
				next_rdata = {28'h000_0000, 1'b0, avf_sel, weakening_loop_on,
					idle_warming_mode_on};
			OFF_INT_GAIN:
				next_rdata = {22'h00_0000, field_int_gain};
			OFF_IDLE_CUR:
				next_rdata = {18'h0_0000, idle_warming_current};
			OFF_QUENCH:
				next_rdata = {19'h0_0000, quench_hold_time};
			OFF_FIELD_REF:
				next_rdata = {18'h0_0000, field_ref};
			OFF_FLOOR:
				next_rdata = {18'h0_0000, field_current_floor};
			OFF_THRESH:
				next_rdata = {18'h0_0000, weakening_threshold_voltage};
			OFF_STATUS:
				next_rdata = {26'h000_0000, state,
					speed_feedback_disagreement_trip, weakening_active,
					contactor_on, running};
			OFF_DEMAND:
				next_rdata = {18'h0_0000, field_demand};
			OFF_INT_STAT:
				next_rdata = {29'h0000_0000, int_stat};
			OFF_INT_EN:
				next_rdata = {29'h0000_0000, int_en};
			OFF_SPD_SCALE:
				next_rdata = {16'h0000, speed_fb_fullscale};
			default:
			begin
				if (wk_sel)
					next_rdata = {22'h00_0000, wk_gain[wk_idx]};
			end
		endcase
	end

	// unmapped and write-only words read zero
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= '0;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// all checks share the one clock and the reset
	default clocking chk_clk @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	int_gain_range_a: assert property ( // RQ1
		field_int_gain <= GAIN_MAX[9:0])
		else $error("integral gain out of range");

	idle_quench_a: assert property ( // RQ2
		(state == FQWC_IDLE && next_state == FQWC_IDLE && !reg_wr)
		|=> field_demand == (idle_warming_mode_on
		? idle_warming_current : 14'h0000))
		else $error("idle field demand wrong");

	// run is never entered unless the run condition stands
	run_decode_a: assert property ( // RQ3
		(state != FQWC_RUN && !running) |=> state != FQWC_RUN)
		else $error("run entered without run condition");

	hold_field_a: assert property ( // RQ5
		(state == FQWC_HOLD && !reg_wr) |=> field_demand == $past(base_demand))
		else $error("field not held during quench delay");

	floor_clamp_a: assert property ( // RQ7
		base_demand >= field_current_floor && base_demand >= field_ref)
		else $error("floor clamp not applied");

	weak_ratio_a: assert property ( // RQ11
		(state == FQWC_RUN) |=> field_demand >= $past(weak_floor))
		else $error("weakening beyond ten to one");

	trip_entry_a: assert property ( // RQ12
		trip_set |=> speed_feedback_disagreement_trip ##1 !contactor_on)
		else $error("disagreement trip missing");

	rescale_a: assert property ( // RQ13
		$rose(avf_sel) |-> speed_fb_fullscale == RATED_ARM_V)
		else $error("speed full scale not rescaled");

	run_drop_a: assert property ( // RQ14
		(state == FQWC_HOLD && !run_s) |=> state == FQWC_IDLE && !contactor_on)
		else $error("run drop did not quench");

	// contactor follows next state, so it is already up on entry
	cancel_a: assert property ( // RQ15
		(state == FQWC_HOLD && running) |=> state == FQWC_RUN && contactor_on)
		else $error("quench not cancelled");
endmodule : fqwc_top

// ### tb/fqwc_motor_model.sv
// ----------------------------------------------------------------
// motor: back emf from speed and field
// ----------------------------------------------------------------
module fqwc_motor_model
	import fqwc_pkg::*;
(
	input wire logic [19:0] speed, // 0.01 % of base speed
	input wire logic [13:0] field_demand, // flux follows demand
	output logic [13:0] armature_voltage
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [35:0] emf; // unclipped emf
	// no field lag: the loop sees its cut at once, harsher than life
	always_comb
	begin
		emf = 36'(speed) * 36'(field_demand) / 36'h0_0000_2710;
		armature_voltage = (emf > 36'h0_0000_3FFF) ? 14'h3FFF : emf[13:0];
	end
endmodule : fqwc_motor_model

// ### tb/tb_field_quench_weakening_control.sv
module tb_field_quench_weakening_control
	import fqwc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic run_pin = 1'b0;
	logic start_pin = 1'b0;
	logic jog_pin = 1'b0;
	logic [19:0] speed = 20'h0_0000; // shaft speed into model
	logic [13:0] armature_voltage;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [13:0] field_demand;
	logic [9:0] field_int_gain;
	logic trip;
	logic contactor_on;
	logic weakening_active;
	logic irq;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [31:0] exp_q[$]; // expected read data, oldest first
	logic rd_d = 1'b0; // read strobe one cycle late
	logic [31:0] g; // random setting
	fqwc_top #(.TICK_CYCLES(4), .RATED_ARM_V(16'h0123)) dut (.clock(clock),
		.arst_n(arst_n), .run_pin(run_pin), .start_pin(start_pin),
		.jog_pin(jog_pin), .armature_voltage(armature_voltage),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.field_demand(field_demand), .field_int_gain(field_int_gain),
		.contactor_on(contactor_on), .speed_feedback_disagreement_trip(trip),
		.weakening_active(weakening_active), .speed_fb_fullscale(),
		.irq(irq));
	fqwc_motor_model motor (.speed(speed), .field_demand(field_demand),
		.armature_voltage(armature_voltage));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		cyc(2); // let the demand register follow
	endtask : wr
	// note the expectation, then strobe; the monitor compares
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		exp_q.push_back(e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask : rd
	// pins are synchronised, so allow state and demand to settle
	task pins(input logic r, input logic s, input logic j);
		@(posedge clock);
		run_pin <= r;
		start_pin <= s;
		jog_pin <= j;
		cyc(8);
	endtask : pins
	// ----------------------------------------------------------------
	// clock, monitor, watchdog
	// ----------------------------------------------------------------
	initial
	begin
		forever #25 clock = ~clock;
	end
	// read data stands only in the cycle after the strobe
	always @(posedge clock)
	begin
		rd_d <= reg_rd;
		if (rd_d)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata);
	end
	// about 9000 cycles expected; a hang is cut at 40000
	initial
	begin
		#(40_000 * 50);
		n_mismatch++;
		summarize();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'hae892fe9));
		cyc(8);
		arst_n <= 1'b1;
		rd(OFF_INT_GAIN, 32'h0000_0064);
		rd(OFF_IDLE_CUR, 32'h0000_09C4);
		rd(OFF_QUENCH, 32'h0000_0064);
		rd(OFF_FIELD_REF, 32'h0000_2710);
		rd(OFF_SPD_SCALE, 32'h0000_2710);
		rd(8'h48, 32'h0000_0000);
		rd(OFF_WK_GAIN4, 32'h0000_0004);
		g = $urandom_range(1000);
		wr(OFF_INT_GAIN, g);
		chk("field_int_gain", g, 32'(field_int_gain));
		wr(OFF_INT_GAIN, 32'h0000_07D0);
		rd(OFF_INT_GAIN, 32'h0000_03E8);
		wr(OFF_IDLE_CUR, 32'h0000_4E20);
		rd(OFF_IDLE_CUR, 32'h0000_2710);
		wr(OFF_QUENCH, 32'h0000_0001);
		wr(OFF_INT_EN, 32'h0000_0007);
		pins(1'b0, 1'b1, 1'b0);
		rd(OFF_STATUS, 32'h0000_0030);
		pins(1'b1, 1'b0, 1'b1);
		rd(OFF_STATUS, 32'h0000_0003);
		chk("contactor_on", 32'h0000_0001, 32'(contactor_on));
		g = 32'h0000_03E8 + $urandom_range(9000);
		wr(OFF_FIELD_REF, g);
		rd(OFF_DEMAND, g);
		wr(OFF_FIELD_REF, 32'h0000_01F4);
		rd(OFF_DEMAND, 32'h0000_03E8);
		wr(OFF_FIELD_REF, 32'h0000_2710);
		wr(OFF_INT_CLR, 32'h0000_0007);
		pins(1'b1, 1'b0, 1'b0);
		rd(OFF_STATUS, 32'h0000_0010);
		rd(OFF_DEMAND, 32'h0000_2710);
		chk("irq", 32'h0000_0001, 32'(irq));
		wr(OFF_INT_CLR, 32'h0000_0007);
		chk("irq", 32'h0000_0000, 32'(irq));
		pins(1'b1, 1'b1, 1'b0);
		rd(OFF_STATUS, 32'h0000_0003);
		pins(1'b1, 1'b0, 1'b0);
		cyc(450); // 100 ticks of 4 clocks, plus margin
		rd(OFF_STATUS, 32'h0000_0030);
		rd(OFF_DEMAND, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0001);
		// idle current was saturated to full scale above
		rd(OFF_DEMAND, 32'h0000_2710);
		wr(OFF_CTRL, 32'h0000_0000);
		pins(1'b1, 1'b1, 1'b0);
		pins(1'b1, 1'b0, 1'b0);
		pins(1'b0, 1'b0, 1'b0);
		rd(OFF_DEMAND, 32'h0000_0000);
		chk("contactor_on", 32'h0000_0000, 32'(contactor_on));
		// weakening: emf would pass the threshold at full field
		wr(OFF_CTRL, 32'h0000_0002);
		speed <= 20'h0_2EE0;
		pins(1'b1, 1'b1, 1'b0);
		cyc(4000);
		rd(OFF_STATUS, 32'h0000_0007);
		chk("hold", 1, 32'(armature_voltage > 14'h2260
			&& armature_voltage < 14'h23F0));
		speed <= 20'h3_0D40;
		cyc(4000);
		rd(OFF_DEMAND, 32'h0000_03E8);
		wr(OFF_CTRL, 32'h0000_0006);
		rd(OFF_SPD_SCALE, 32'h0000_0123);
		chk("trip", 1, 32'(trip));
		cyc(3);
		summarize();
	end
endmodule : tb_field_quench_weakening_control
